// *** pkg/sfd_pkg.sv ***
package sfd_pkg;

  // ************************************************************
  // Frame geometry
  // ************************************************************
  localparam int ADDR_W   = 5;
  localparam int FUNC_W   = 5;
  localparam int HDR_W    = ADDR_W + FUNC_W;
  localparam int MASK_W   = 68;
  localparam int DAC_W    = 14;
  localparam int MODE_W   = 2;
  localparam int TAG_W    = 2;
  localparam int NCHAN    = 64;
  localparam int NBUF     = 4;
  localparam int CNT_W    = 7;
  localparam int GRP_W    = 16;
  localparam int EVT_HDR  = 3;
  localparam int DAC_HALF = 7;

  localparam logic [CNT_W-1:0] LEN_NONE = 7'h00;
  localparam logic [CNT_W-1:0] LEN_TAG  = 7'h02;
  localparam logic [CNT_W-1:0] LEN_LONG = 7'h44;

  localparam logic [ADDR_W-1:0] BCAST_ADDR = 5'h1f;

  // ************************************************************
  // Function codes
  // ************************************************************
  localparam logic [FUNC_W-1:0] FN_NOP       = 5'h00;
  localparam logic [FUNC_W-1:0] FN_RESET     = 5'h02;
  localparam logic [FUNC_W-1:0] FN_CAL       = 5'h03;
  localparam logic [FUNC_W-1:0] FN_READ_EVT  = 5'h04;
  localparam logic [FUNC_W-1:0] FN_LD_HIT    = 5'h08;
  localparam logic [FUNC_W-1:0] FN_LD_INJ    = 5'h09;
  localparam logic [FUNC_W-1:0] FN_LD_TRIG   = 5'h0a;
  localparam logic [FUNC_W-1:0] FN_LD_DAC    = 5'h0b;
  localparam logic [FUNC_W-1:0] FN_LD_MODE   = 5'h0c;
  localparam logic [FUNC_W-1:0] FN_RD_HIT    = 5'h10;
  localparam logic [FUNC_W-1:0] FN_RD_INJ    = 5'h11;
  localparam logic [FUNC_W-1:0] FN_RD_TRIG   = 5'h12;
  localparam logic [FUNC_W-1:0] FN_RD_DAC    = 5'h13;
  localparam logic [FUNC_W-1:0] FN_RD_MODE   = 5'h14;

  // ************************************************************
  // Register layout and reset values
  // ************************************************************
  localparam int MODE_DIR_BIT  = 1;
  localparam int MODE_MUTE_BIT = 0;
  localparam logic [MASK_W-1:0] MASK_RST = 68'h0;
  localparam logic [DAC_W-1:0]  DAC_RST  = 14'h0000;
  localparam logic [MODE_W-1:0] MODE_RST = 2'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [FUNC_W-1:0] func;
    logic [MASK_W-1:0] data;
  } sfd_frame_t;

  typedef struct packed {
    logic bit_val;
    logic is_reg;
  } sfd_obit_t;

  // Data field length that a function code carries.
  function automatic logic [CNT_W-1:0] sfd_data_len(input logic [FUNC_W-1:0] f);
    sfd_data_len = LEN_NONE;
    if (f == FN_READ_EVT) begin
      sfd_data_len = LEN_TAG;
    end else if (f >= FN_LD_HIT && f <= FN_LD_MODE) begin
      sfd_data_len = LEN_LONG;
    end
  endfunction

  // Strips the four filler bits out of a mask, one filler after each group.
  function automatic logic [NCHAN-1:0] sfd_chan_map(input logic [MASK_W-1:0] m);
    sfd_chan_map = '0;
    for (int i = 0; i < NCHAN; i++) begin
      sfd_chan_map[i] = m[i + i / GRP_W];
    end
  endfunction

endpackage

// *** rtl/sfd_frame_rx.sv ***
`timescale 1ns/100ps
module sfd_frame_rx
  import sfd_pkg::*;
(
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst,
  // Link pins
  input  wire logic   link_clk_pin,
  input  wire logic   cmd_pin,
  // Decoded frames
  output logic        link_rise,
  output logic        frame_valid,
  output sfd_frame_t  frame
);

  typedef enum logic [1:0] {RX_IDLE, RX_HDR, RX_DATA} sfd_rx_state_t;

  logic              clk_s1_q, clk_s2_q, clk_s3_q;
  logic              cmd_s1_q, cmd_s2_q;
  logic              rise;
  sfd_rx_state_t     state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [HDR_W-1:0]  hdr_q;
  logic [MASK_W-1:0] data_q;
  logic [FUNC_W-1:0] func_now;
  logic [CNT_W-1:0]  len_now;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      cmd_s1_q <= 1'b0;
      cmd_s2_q <= 1'b0;
    end else begin
      clk_s1_q <= link_clk_pin;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      cmd_s1_q <= cmd_pin;
      cmd_s2_q <= cmd_s1_q;
    end
  end

  assign rise     = clk_s2_q & ~clk_s3_q;
  assign func_now = {hdr_q[FUNC_W-2:0], cmd_s2_q};
  assign len_now  = sfd_data_len(func_now);

  // ************************************************************
  // Frame parser
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q     <= RX_IDLE;
      cnt_q       <= '0;
      hdr_q       <= '0;
      data_q      <= '0;
      frame_valid <= 1'b0;
      frame       <= '0;
      link_rise   <= 1'b0;
    end else begin
      link_rise   <= rise;
      frame_valid <= 1'b0;
      if (rise) begin
        unique case (state_q)
          RX_IDLE: begin
            if (cmd_s2_q) begin
              state_q <= RX_HDR;
              cnt_q   <= CNT_W'(HDR_W - 1);
              data_q  <= '0;
            end
          end
          RX_HDR: begin
            hdr_q <= {hdr_q[HDR_W-2:0], cmd_s2_q};
            cnt_q <= cnt_q - 7'h01;
            if (cnt_q == '0) begin
              if (len_now == LEN_NONE) begin
                state_q     <= RX_IDLE;
                frame_valid <= 1'b1;
                frame       <= '{addr: hdr_q[HDR_W-2:FUNC_W-1], func: func_now, data: '0};
              end else begin
                state_q <= RX_DATA;
                cnt_q   <= len_now - 7'h01;
              end
            end
          end
          RX_DATA: begin
            data_q <= {data_q[MASK_W-2:0], cmd_s2_q};
            cnt_q  <= cnt_q - 7'h01;
            if (cnt_q == '0) begin
              state_q     <= RX_IDLE;
              frame_valid <= 1'b1;
              frame       <= '{addr: hdr_q[HDR_W-1:FUNC_W], func: hdr_q[FUNC_W-1:0],
                               data: {data_q[MASK_W-2:0], cmd_s2_q}};
            end
          end
        endcase
      end
    end
  end

endmodule

// *** rtl/sfd_cmd_decoder.sv ***
`timescale 1ns/100ps
module sfd_cmd_decoder
  import sfd_pkg::*;
#(
  parameter int BUF_DEPTH = 2
)
(
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        reset_pin,
  // Hard-wired chip address
  input  wire logic [ADDR_W-1:0]           chip_addr_pin,
  // Left and right controller links
  input  wire logic                        clk_left_pin,
  input  wire logic                        cmd_left_pin,
  input  wire logic                        clk_right_pin,
  input  wire logic                        cmd_right_pin,
  // Event buffers from the channel logic
  input  wire logic [NBUF-1:0][NCHAN-1:0]  event_buf_bits,
  // Register read-back pin
  output logic                             config_readback_pin_o,
  output logic                             config_readback_pin_oe,
  // Event data output
  output logic                             event_data_out,
  output logic                             event_data_valid,
  // Configuration to the analog side
  output logic [NCHAN-1:0]                 hit_enable,
  output logic [NCHAN-1:0]                 charge_inject,
  output logic [NCHAN-1:0]                 trigger_enable,
  output logic [DAC_HALF-1:0]              inject_level,
  output logic [DAC_HALF-1:0]              threshold_level,
  output logic                             readout_direction,
  output logic                             input_mute_bit,
  output logic                             cal_strobe
);

  typedef enum logic [1:0] {SQ_IDLE, SQ_SHIFT} sfd_seq_state_t;

  // ************************************************************
  // Pin synchronisers and reset
  // ************************************************************
  logic              rst_s1_q, rst_s2_q;
  logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
  logic              reset_cmd_q;
  logic              chip_rst;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_s1_q  <= 1'b0;
      rst_s2_q  <= 1'b0;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
    end else begin
      rst_s1_q  <= reset_pin;
      rst_s2_q  <= rst_s1_q;
      addr_s1_q <= chip_addr_pin;
      addr_s2_q <= addr_s1_q;
    end
  end

  assign chip_rst = rst | rst_s2_q | reset_cmd_q;

  // ************************************************************
  // Link receivers
  // ************************************************************
  logic [1:0]       rx_rise;
  logic [1:0]       rx_valid;
  sfd_frame_t [1:0] rx_frame;

  sfd_frame_rx u_rx_left (
    .sys_clk      (sys_clk),
    .rst          (chip_rst),
    .link_clk_pin (clk_left_pin),
    .cmd_pin      (cmd_left_pin),
    .link_rise    (rx_rise[0]),
    .frame_valid  (rx_valid[0]),
    .frame        (rx_frame[0])
  );

  sfd_frame_rx u_rx_right (
    .sys_clk      (sys_clk),
    .rst          (chip_rst),
    .link_clk_pin (clk_right_pin),
    .cmd_pin      (cmd_right_pin),
    .link_rise    (rx_rise[1]),
    .frame_valid  (rx_valid[1]),
    .frame        (rx_frame[1])
  );

  // ************************************************************
  // Address match and side selection
  // ************************************************************
  logic [MASK_W-1:0] hit_mask_q, inj_mask_q, trig_mask_q;
  logic [DAC_W-1:0]  dac_q;
  logic [MODE_W-1:0] mode_q;
  logic [1:0]        acc;
  logic              cmd_go;
  logic              cmd_side;
  sfd_frame_t        cmd;

  // The direction bit also chooses which controller this chip listens to, for all frames but broadcast mode loads (either side) and broadcast reads (dropped).
  always_comb begin
    acc = '0;
    for (int s = 0; s < 2; s++) begin
      if (rx_valid[s]) begin
        if (rx_frame[s].addr == addr_s2_q) begin
          acc[s] = (mode_q[MODE_DIR_BIT] == s[0]);
        end else if (rx_frame[s].addr == BCAST_ADDR) begin
          acc[s] = (mode_q[MODE_DIR_BIT] == s[0])
                 || (rx_frame[s].func == FN_LD_MODE);
          if (rx_frame[s].func >= FN_RD_HIT && rx_frame[s].func <= FN_RD_MODE) begin
            acc[s] = 1'b0;
          end
        end
      end
    end
    cmd_go   = |acc;
    cmd_side = ~acc[0];
    cmd      = acc[0] ? rx_frame[0] : rx_frame[1];
  end

  // ************************************************************
  // Command execution
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_cmd_q <= 1'b0;
    end else begin
      reset_cmd_q <= cmd_go && (cmd.func == FN_RESET);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      hit_mask_q  <= MASK_RST;
      inj_mask_q  <= MASK_RST;
      trig_mask_q <= MASK_RST;
      dac_q       <= DAC_RST;
      mode_q      <= MODE_RST;
      cal_strobe  <= 1'b0;
    end else begin
      cal_strobe <= cmd_go && (cmd.func == FN_CAL);
      if (cmd_go) begin
        // Filler bits are stored as sent.
        unique case (cmd.func)
          FN_LD_HIT:  hit_mask_q  <= cmd.data;
          FN_LD_INJ:  inj_mask_q  <= cmd.data;
          FN_LD_TRIG: trig_mask_q <= cmd.data;
          FN_LD_DAC:  dac_q       <= cmd.data[DAC_W-1:0];
          FN_LD_MODE: mode_q      <= cmd.data[MODE_W-1:0];
          default:    ;
        endcase
      end
    end
  end

  // ************************************************************
  // Configuration outputs
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      hit_enable        <= '0;
      charge_inject     <= '0;
      trigger_enable    <= '0;
      inject_level      <= '0;
      threshold_level   <= '0;
      readout_direction <= 1'b0;
      input_mute_bit    <= 1'b0;
    end else begin
      hit_enable        <= sfd_chan_map(hit_mask_q);
      charge_inject     <= sfd_chan_map(inj_mask_q);
      trigger_enable    <= sfd_chan_map(trig_mask_q);
      inject_level      <= dac_q[DAC_W-1:DAC_HALF];
      threshold_level   <= dac_q[DAC_HALF-1:0];
      readout_direction <= mode_q[MODE_DIR_BIT];
      input_mute_bit    <= mode_q[MODE_MUTE_BIT];
    end
  end

  // ************************************************************
  // Output bit sequencer
  // ************************************************************
  sfd_seq_state_t    seq_q;
  logic [MASK_W-1:0] vec_q;
  logic [CNT_W-1:0]  left_q;
  logic              is_reg_q;
  logic              side_q;
  logic              push;
  logic              buf_ready;
  logic [NCHAN-1:0]  ev_bits;
  logic [NCHAN-1:0]  ev_ord;
  logic              ev_hit;
  logic [MASK_W-1:0] load_vec;
  logic              load_reg;
  logic              load_go;

  always_comb begin
    ev_bits = event_buf_bits[cmd.data[TAG_W-1:0]];
    ev_hit  = |ev_bits;
    for (int i = 0; i < NCHAN; i++) begin
      ev_ord[i] = mode_q[MODE_DIR_BIT] ? ev_bits[i] : ev_bits[NCHAN-1-i];
    end
    load_vec = '0;
    load_reg = 1'b1;
    load_go  = cmd_go && (seq_q == SQ_IDLE);
    unique case (cmd.func)
      FN_READ_EVT: begin
        load_vec = {cmd.data[TAG_W-1:0], ev_hit, ev_ord, 1'b0};
        load_reg = 1'b0;
      end
      FN_RD_HIT:  load_vec = hit_mask_q;
      FN_RD_INJ:  load_vec = inj_mask_q;
      FN_RD_TRIG: load_vec = trig_mask_q;
      FN_RD_DAC:  load_vec = {dac_q, {(MASK_W-DAC_W){1'b0}}};
      FN_RD_MODE: load_vec = {mode_q, {(MASK_W-MODE_W){1'b0}}};
      default:    load_go  = 1'b0;
    endcase
  end

  assign push = (seq_q == SQ_SHIFT) && buf_ready;

  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      seq_q    <= SQ_IDLE;
      vec_q    <= '0;
      left_q   <= '0;
      is_reg_q <= 1'b0;
      side_q   <= 1'b0;
    end else begin
      unique case (seq_q)
        SQ_IDLE: begin
          if (load_go) begin
            seq_q    <= SQ_SHIFT;
            vec_q    <= load_vec;
            is_reg_q <= load_reg;
            side_q   <= cmd_side;
            if (!load_reg && !ev_hit) begin
              left_q <= CNT_W'(EVT_HDR);
            end else if (!load_reg) begin
              left_q <= CNT_W'(EVT_HDR + NCHAN);
            end else begin
              left_q <= LEN_LONG;
            end
          end
        end
        SQ_SHIFT: begin
          if (push) begin
            vec_q  <= {vec_q[MASK_W-2:0], 1'b0};
            left_q <= left_q - 7'h01;
            if (left_q == 7'h01) begin
              seq_q <= SQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Two-entry output buffer
  // ************************************************************
  sfd_obit_t                     buf_q [BUF_DEPTH];
  logic [$clog2(BUF_DEPTH)-1:0]  wr_q, rd_q;
  logic [$clog2(BUF_DEPTH):0]    cnt_q;
  logic                          buf_valid;
  logic                          pop;

  assign buf_ready = (cnt_q != BUF_DEPTH[$clog2(BUF_DEPTH):0]);
  assign buf_valid = (cnt_q != '0);
  assign pop       = buf_valid && rx_rise[side_q];

  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        buf_q[wr_q] <= '{bit_val: vec_q[MASK_W-1], is_reg: is_reg_q};
        wr_q        <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{$clog2(BUF_DEPTH){1'b0}}, push} - {{$clog2(BUF_DEPTH){1'b0}}, pop};
    end
  end

  // ************************************************************
  // Pin drivers, one bit per link clock edge
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (chip_rst) begin
      config_readback_pin_o  <= 1'b0;
      config_readback_pin_oe <= 1'b0;
      event_data_out         <= 1'b0;
      event_data_valid       <= 1'b0;
    end else if (rx_rise[side_q]) begin
      config_readback_pin_o  <= pop && buf_q[rd_q].is_reg && buf_q[rd_q].bit_val;
      config_readback_pin_oe <= pop && buf_q[rd_q].is_reg;
      event_data_out         <= pop && !buf_q[rd_q].is_reg && buf_q[rd_q].bit_val;
      event_data_valid       <= pop && !buf_q[rd_q].is_reg;
    end
  end

endmodule

// *** sim/sfd_cmd_decoder_assertions.sv ***
`timescale 1ns/100ps
module sfd_cmd_decoder_assertions
  import sfd_pkg::*;
(
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             rst,
  // Link clocks
  input wire logic             clk_left_pin,
  input wire logic             clk_right_pin,
  // Observed outputs
  input wire logic             config_readback_pin_o,
  input wire logic             config_readback_pin_oe,
  input wire logic             event_data_out,
  input wire logic             event_data_valid,
  input wire logic [NCHAN-1:0] hit_enable,
  input wire logic             readout_direction,
  input wire logic             input_mute_bit,
  input wire logic             cal_strobe
);
  // Link rises seen here lead the decoder's synchronised view by two stages.
  logic       lk_q;
  logic       rise;
  logic [6:0] rc_q;
  logic [6:0] ec_q;
  logic [3:0] since_q;
  logic       hit_q;

  assign rise = (clk_left_pin | clk_right_pin) & ~lk_q;

  always_ff @(posedge sys_clk) begin
    lk_q <= clk_left_pin | clk_right_pin;
  end
  always_ff @(posedge sys_clk) begin
    if (rst || rise) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst || !config_readback_pin_oe) rc_q <= 7'h00;
    else if (rise) rc_q <= rc_q + 7'h01;
  end
  always_ff @(posedge sys_clk) begin
    if (rst || !event_data_valid) ec_q <= 7'h00;
    else if (rise) ec_q <= ec_q + 7'h01;
  end
  always_ff @(posedge sys_clk) begin
    if (rise && event_data_valid && ec_q == 7'h02) hit_q <= event_data_out;
  end

  a_strobe_single: assert property (@(posedge sys_clk) disable iff (rst)
    cal_strobe |=> !cal_strobe) else $error("strobe too long");
  a_strobe_prompt: assert property (@(posedge sys_clk) disable iff (rst)
    cal_strobe |-> since_q <= 4'h7) else $error("strobe not after a frame");
  a_reset_quiet_out: assert property (@(posedge sys_clk)
    rst |=> !config_readback_pin_oe && !event_data_valid && !cal_strobe)
    else $error("outputs active in reset");
  a_reset_clears_cfg: assert property (@(posedge sys_clk)
    rst |=> hit_enable == '0 && !readout_direction && !input_mute_bit)
    else $error("config not cleared in reset");
  a_rb_length: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(config_readback_pin_oe) |-> rc_q == 7'd68) else $error("readback length");
  a_event_length: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(event_data_valid) |-> ec_q == (hit_q ? 7'd67 : 7'd3)) else $error("event length");
  a_rb_bit_stands: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(config_readback_pin_o) && config_readback_pin_oe && $past(config_readback_pin_oe)
    |-> since_q <= 4'h4) else $error("readback bit moved off a link edge");
  a_mask_prompt: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(hit_enable) && hit_enable != '0 |-> since_q inside {[1:7]})
    else $error("mask changed off a frame");
endmodule

bind sfd_cmd_decoder sfd_cmd_decoder_assertions sfd_cmd_decoder_assertions_inst (
  .sys_clk(sys_clk), .rst(rst), .clk_left_pin(clk_left_pin), .clk_right_pin(clk_right_pin),
  .config_readback_pin_o(config_readback_pin_o),
  .config_readback_pin_oe(config_readback_pin_oe), .event_data_out(event_data_out),
  .event_data_valid(event_data_valid), .hit_enable(hit_enable),
  .readout_direction(readout_direction), .input_mute_bit(input_mute_bit),
  .cal_strobe(cal_strobe));

// *** sim/sfd_ctrl_model.sv ***
`timescale 1ns/100ps
module sfd_ctrl_model
  import sfd_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Link pins, both ends
  output logic     clk_l,
  output logic     cmd_l,
  output logic     clk_r,
  output logic     cmd_r
);
  logic side;

  initial begin
    side = 1'b0;
    clk_l = 1'b0;
    clk_r = 1'b0;
    cmd_l = 1'b0;
    cmd_r = 1'b0;
  end

  // One link bit; only the sending end's clock moves, two cycles each phase.
  task automatic tick(input logic b);
    @(posedge sys_clk);
    #1;
    cmd_l = b;
    cmd_r = b;
    clk_l = 1'b0;
    clk_r = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    clk_l = !side;
    clk_r = side;
    @(posedge sys_clk);
  endtask

  task automatic send(input logic [ADDR_W-1:0] a, input logic [FUNC_W-1:0] f,
                      input logic [MASK_W-1:0] d, input int n);
    logic [HDR_W:0] h;
    h = {1'b1, a, f};
    for (int i = HDR_W; i >= 0; i--) tick(h[i]);
    for (int i = n - 1; i >= 0; i--) tick(d[i]);
  endtask

  // Clocks that carry no start bit, used while the chip shifts out.
  task automatic pad(input int n);
    for (int i = 0; i < n; i++) tick(1'b0);
  endtask
endmodule

// *** sim/tb_strip_frontend_command_decoder.sv ***
`timescale 1ns/100ps
module tb_strip_frontend_command_decoder
  import sfd_pkg::*;
;
  localparam logic [MASK_W-1:0] FILL = 68'h8_0004_0002_0001_0000;
  logic                       sys_clk = 1'b0;
  logic                       rst;
  logic                       reset_pin;
  logic                       xdir;
  logic [ADDR_W-1:0]          addr;
  logic [NBUF-1:0][NCHAN-1:0] ebuf;
  logic                       clk_l, cmd_l, clk_r, cmd_r, rb_o, rb_oe, ev_o, ev_v, dir, mute, cal;
  logic [NCHAN-1:0]           hit_en, inj_en, trg_en;
  logic [DAC_HALF-1:0]        inj_lv, thr_lv;
  logic [2:0][MASK_W-1:0]     mk;
  logic [MASK_W-1:0]          v, racc, eacc;
  logic [75:0]                rb_q[$], ev_q[$];
  logic [FUNC_W-1:0]          und[5] = '{5'h00, 5'h01, 5'h07, 5'h0f, 5'h1f};
  int                         rn, en, ncal, cyc, bad_count, checked;
  integer                     seed = 32'h892e;
  wire                        lclk = clk_l | clk_r;
  wire [2:0][NCHAN-1:0]       outs = {trg_en, inj_en, hit_en};

  always #50 sys_clk = ~sys_clk;

  sfd_ctrl_model sfd_ctrl_model_inst (.sys_clk(sys_clk), .clk_l(clk_l), .cmd_l(cmd_l),
    .clk_r(clk_r), .cmd_r(cmd_r));
  sfd_cmd_decoder sfd_cmd_decoder_inst (.sys_clk(sys_clk), .rst(rst), .reset_pin(reset_pin),
    .chip_addr_pin(addr), .clk_left_pin(clk_l), .cmd_left_pin(cmd_l), .clk_right_pin(clk_r),
    .cmd_right_pin(cmd_r), .event_buf_bits(ebuf), .config_readback_pin_o(rb_o),
    .config_readback_pin_oe(rb_oe), .event_data_out(ev_o), .event_data_valid(ev_v),
    .hit_enable(hit_en), .charge_inject(inj_en), .trigger_enable(trg_en), .inject_level(inj_lv),
    .threshold_level(thr_lv), .readout_direction(dir), .input_mute_bit(mute), .cal_strobe(cal));

  task automatic cmp_ser(input logic [75:0] e, input logic [75:0] g);
    checked++;
    if (e !== g) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_lvl(input logic [67:0] e, input logic [67:0] g);
    checked++;
    if (e !== g) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [67:0] chans(input logic [67:0] m);
    return 68'({m[66:51], m[49:34], m[32:17], m[15:0]});
  endfunction

  task automatic ld(input logic [4:0] a, input logic [4:0] f, input logic [67:0] d, input int n);
    sfd_ctrl_model_inst.send(a, f, d, n);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [4:0] f, input logic [67:0] e);
    rb_q.push_back({8'd68, e});
    sfd_ctrl_model_inst.send(addr, f, 68'h0, 0);
    sfd_ctrl_model_inst.pad(74);
  endtask
  task automatic ev(input logic [1:0] t);
    logic [NCHAN-1:0] c;
    c = ebuf[t];
    if (!xdir) c = {<<{c}};
    if (|c) ev_q.push_back({8'd67, 1'b0, t, 1'b1, c});
    else ev_q.push_back({8'd3, 65'h0, t, 1'b0});
    sfd_ctrl_model_inst.send(addr, FN_READ_EVT, {66'h0, t}, 2);
    sfd_ctrl_model_inst.pad(74);
  endtask

  // Serial results are gathered one bit per link rise, while enable is high.
  always @(posedge lclk) begin
    if (rb_oe === 1'b1) begin
      racc = {racc[66:0], rb_o};
      rn++;
    end else if (rn != 0) begin
      cmp_ser(rb_q.pop_front(), {8'(rn), racc});
      rn = 0;
      racc = '0;
    end
    if (ev_v === 1'b1) begin
      eacc = {eacc[66:0], ev_o};
      en++;
    end else if (en != 0) begin
      cmp_ser(ev_q.pop_front(), {8'(en), eacc});
      en = 0;
      eacc = '0;
    end
  end

  always @(posedge sys_clk) begin
    if (cal === 1'b1) ncal++;
    cyc++;
    if (cyc == 50000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    rst = 1'b1;
    reset_pin = 1'b0;
    xdir = 1'b0;
    racc = '0;
    eacc = '0;
    addr = 5'($unsigned($random(seed)) % 30);
    for (int b = 0; b < NBUF; b++) ebuf[b] = {$random(seed), $random(seed)};
    ebuf[2] = '0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    for (int k = 0; k < 5; k++) rd(FN_RD_HIT + 5'(k), 68'h0);
    for (int k = 0; k < 3; k++) begin
      mk[k] = 68'({$random(seed), $random(seed), $random(seed)}) | FILL;
      ld(addr, FN_LD_HIT + 5'(k), mk[k], 68);
      cmp_lvl(chans(mk[k]), 68'(outs[k]));
      rd(FN_RD_HIT + 5'(k), mk[k]);
    end
    ld(addr ^ 5'h01, FN_LD_HIT, mk[1], 68);
    cmp_lvl(chans(mk[0]), 68'(hit_en));
    ld(BCAST_ADDR, FN_LD_HIT, mk[1], 68);
    cmp_lvl(chans(mk[1]), 68'(hit_en));
    rd(FN_RD_TRIG, mk[2]);
    // A broadcast read must stay silent; any output would pop an empty queue and mismatch.
    sfd_ctrl_model_inst.send(BCAST_ADDR, FN_RD_TRIG, 68'h0, 0);
    sfd_ctrl_model_inst.pad(74);
    foreach (und[i]) ld(addr, und[i], 68'h0, 0);
    cmp_lvl(chans(mk[1]), 68'(hit_en));
    v = 68'({$random(seed), $random(seed), $random(seed)});
    ld(addr, FN_LD_DAC, v, 68);
    cmp_lvl(68'(v[13:0]), 68'({inj_lv, thr_lv}));
    rd(FN_RD_DAC, {v[13:0], 54'h0});
    ld(addr, FN_LD_MODE, {v[67:2], 2'b01}, 68);
    cmp_lvl(68'h1, 68'({dir, mute}));
    rd(FN_RD_MODE, {2'b01, 66'h0});
    ld(addr, FN_CAL, 68'h0, 0);
    cmp_lvl(68'h1, 68'(ncal));
    for (int t = 0; t < NBUF; t++) ev(2'(t));
    ld(addr, FN_LD_MODE, 68'h2, 68);
    xdir = 1'b1;
    sfd_ctrl_model_inst.side = 1'b1;
    for (int t = 0; t < NBUF; t++) ev(2'(t));
    sfd_ctrl_model_inst.side = 1'b0;
    ld(addr, FN_LD_HIT, mk[2], 68);
    cmp_lvl(chans(mk[1]), 68'(hit_en));
    ld(BCAST_ADDR, FN_LD_MODE, 68'h0, 68);
    cmp_lvl(68'h0, 68'(dir));
    ld(addr, FN_RESET, 68'h0, 0);
    cmp_lvl(68'h0, 68'(hit_en | 64'({inj_lv, thr_lv})));
    ld(addr, FN_LD_HIT, mk[0], 68);
    cmp_lvl(chans(mk[0]), 68'(hit_en));
    reset_pin = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    reset_pin = 1'b0;
    repeat (4) @(posedge sys_clk);
    cmp_lvl(68'h0, 68'(hit_en));
    cmp_lvl(68'h0, 68'(rb_q.size() + ev_q.size()));
    stop_test();
  end
endmodule
